// File: rtl/see_pkg.sv
// Overview of operation
// - data bits sampled on rising serial clock
// - select byte msb first, type identifier matched
// - respond only when chip bits match straps
// - select last bit: one read, zero write
// - match acks ninth slot, mismatch goes standby
// - write select, two address bytes, all acked
// - seventeen-bit address, top bit in select
// - write protect seen: no change, data nacked
// - only stop in tenth slot starts programming
// - counter ends after last modified byte
// - busy programming: released line, no acks
// - page write holds 1 to 256 bytes
// - page write increments only low eight bits
// - six check bits correct one bit error
// - any byte write reprograms whole word
// - reads ignore the write protect level
// - random read: dummy write then read select
// - current read returns counter byte, increments
// - acked read continues, counter wraps to zero
// - read nack in ninth slot means standby
// - start is falling data while clock high
// - stop is rising data while clock high
package see_pkg;
    // identifier value is arbitrary
    localparam logic [3:0] SEE_TYPE_ID = 4'h6;
    localparam int SEE_ADDR_W = 17;
    localparam int SEE_PAGE_W = 8;
    localparam int SEE_PAGE_BYTES = 256;
    localparam int SEE_WORD_W = SEE_ADDR_W - 2;
    localparam int SEE_DATA_W = 32;
    localparam int SEE_CHECK_W = 6;
    localparam int SEE_CODE_W = SEE_DATA_W + SEE_CHECK_W;
    localparam int SEE_CLK_NS = 40;
    localparam int SEE_PROG_TIME_NS = 5000000;
    localparam int SEE_PROG_CYCLES = (SEE_PROG_TIME_NS + SEE_CLK_NS - 1) / SEE_CLK_NS;
    localparam logic [3:0] SEE_BIT_FIRST = 4'h0;
    localparam logic [3:0] SEE_BIT_LAST = 4'h7;
    localparam logic [3:0] SEE_ACK_SLOT = 4'h8;
    localparam int SEE_SEL_DIR = 0;
    localparam int SEE_SEL_TOP = 1;
    localparam int SEE_SEL_STRAP_LO = 2;
    localparam int SEE_SEL_STRAP_HI = 3;
    localparam int SEE_SEL_ID_LSB = 4;
    localparam logic [SEE_DATA_W-1:0] SEE_ERASED = 32'hffffffff;

    typedef enum logic [2:0] {
        SEE_IDLE = 3'h0,
        SEE_SEL = 3'h1,
        SEE_ADDR_HI = 3'h3,
        SEE_ADDR_LO = 3'h2,
        SEE_WDATA = 3'h6,
        SEE_RDATA = 3'h7,
        SEE_PROG = 3'h5
    } see_state_t;

    // codeword position of data bit j, skipping powers of two
    function automatic logic [SEE_CHECK_W-1:0] see_pos(input int j);
        int cnt;
        logic [SEE_CHECK_W-1:0] res;
        cnt = -1;
        res = '0;
        for (int p = 1; p <= SEE_CODE_W; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                cnt++;
                if (cnt == j)
                begin
                    res = SEE_CHECK_W'(p);
                end
            end
        end
        return res;
    endfunction

    function automatic logic [SEE_CHECK_W-1:0] see_check(input logic [SEE_DATA_W-1:0] d);
        logic [SEE_CHECK_W-1:0] c;
        c = '0;
        for (int j = 0; j < SEE_DATA_W; j++)
        begin
            if (d[j])
            begin
                c = c ^ see_pos(j);
            end
        end
        return c;
    endfunction
endpackage

// File: rtl/see_ecc.sv
module see_ecc
(
    input wire logic [see_pkg::SEE_CODE_W-1:0] code,
    output logic [see_pkg::SEE_DATA_W-1:0] data
);
    import see_pkg::*;

    wire [SEE_CHECK_W-1:0] stored = code[SEE_CODE_W-1:SEE_DATA_W];
    wire [SEE_DATA_W-1:0] raw = code[SEE_DATA_W-1:0];
    wire [SEE_CHECK_W-1:0] syndrome = stored ^ see_check(raw);

    // flip the one data bit that the syndrome names
    for (genvar j = 0; j < SEE_DATA_W; j++)
    begin : g_fix
        assign data[j] = raw[j] ^ (syndrome == see_pos(j));
    end
endmodule // see_ecc

// File: rtl/see_slave.sv
module see_slave
#(
    parameter int PROG_CYCLES = see_pkg::SEE_PROG_CYCLES
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic chip_strap_low,
    input wire logic chip_strap_high,
    input wire logic write_protect_input,
    output logic program_busy
);
    import see_pkg::*;

    if (PROG_CYCLES < SEE_PAGE_BYTES + 1)
    begin : g_bad_cycles
        $error("PROG_CYCLES must exceed the page size");
    end

    localparam int TW = $clog2(PROG_CYCLES + 1);
    localparam int WORDS = 1 << SEE_WORD_W;

    ////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers
    logic rst_q1, rst_q2;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end
    wire rst_s_n = rst_q2;

    logic [4:0] in_q1, in_q2;
    logic scl_d, sda_d;
    wire [4:0] pins = {write_protect_input, chip_strap_high, chip_strap_low, sda_in, scl_in};
    always_ff @(posedge mclk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            in_q1 <= 5'h03;
            in_q2 <= 5'h03;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            in_q1 <= pins;
            in_q2 <= in_q1;
            scl_d <= in_q2[0];
            sda_d <= in_q2[1];
        end
    end
    wire scl_s = in_q2[0];
    wire sda_s = in_q2[1];
    wire strap_lo = in_q2[2];
    wire strap_hi = in_q2[3];
    wire wp_s = in_q2[4];

    ////////////////////////////////////////////////////////////////////////
    // bus events
    see_state_t state, next_state;
    logic [3:0] bit_cnt;
    logic [7:0] sh, tx;
    logic ack_pend, wp_seen;
    logic [SEE_ADDR_W-1:0] addr;
    logic [7:0] page_buf [SEE_PAGE_BYTES];
    logic [SEE_PAGE_BYTES-1:0] valid;
    logic [SEE_PAGE_W-1:0] prog_idx;
    logic commit_on;
    logic [TW-1:0] timer;
    logic [SEE_CODE_W-1:0] mem [WORDS];

    wire busy = (state == SEE_PROG);
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_ev = scl_s & scl_d & ~sda_d & sda_s;
    wire active = (state != SEE_IDLE) && !busy;
    wire [7:0] rx_byte = {sh[6:0], sda_s};
    wire byte_done = active && scl_rise && (bit_cnt == SEE_BIT_LAST);
    wire ack_done = active && scl_rise && (bit_cnt == SEE_ACK_SLOT);
    wire sel_match = (rx_byte[7:SEE_SEL_ID_LSB] == SEE_TYPE_ID)
        && (rx_byte[SEE_SEL_STRAP_HI] == strap_hi)
        && (rx_byte[SEE_SEL_STRAP_LO] == strap_lo);
    // stop lands after the tenth rise, so one bit is already counted
    wire prog_trig = stop_ev && (state == SEE_WDATA) && (bit_cnt == SEE_BIT_FIRST + 4'h1)
        && (|valid) && !wp_seen;
    wire prog_done = busy && (timer == TW'(PROG_CYCLES - 1));
    wire wr_ok = ack_done && (state == SEE_WDATA) && !wp_seen;
    wire rx_sel_read = sh[SEE_SEL_DIR];

    ////////////////////////////////////////////////////////////////////////
    // read path and program path through the corrector
    wire [SEE_DATA_W-1:0] rd_word, pg_word;
    see_ecc u_rd_ecc
    (
        .code(mem[addr[SEE_ADDR_W-1:2]]),
        .data(rd_word)
    );
    wire [SEE_WORD_W-1:0] pg_index = {addr[SEE_ADDR_W-1:SEE_PAGE_W], prog_idx[SEE_PAGE_W-1:2]};
    see_ecc u_pg_ecc
    (
        .code(mem[pg_index]),
        .data(pg_word)
    );
    wire [7:0] rd_byte = rd_word[8 * addr[1:0] +: 8];
    wire [SEE_DATA_W-1:0] merged;
    for (genvar l = 0; l < 4; l++)
    begin : g_lane
        assign merged[8 * l +: 8] = (prog_idx[1:0] == 2'(l)) ? page_buf[prog_idx]
            : pg_word[8 * l +: 8];
    end
    wire commit = busy && commit_on && valid[prog_idx];

    ////////////////////////////////////////////////////////////////////////
    // protocol state
    always_comb
    begin
        next_state = state;
        if (busy)
        begin
            if (prog_done)
            begin
                next_state = SEE_IDLE;
            end
        end
        else if (start_ev)
        begin
            next_state = SEE_SEL;
        end
        else if (stop_ev)
        begin
            next_state = prog_trig ? SEE_PROG : SEE_IDLE;
        end
        else if (byte_done && (state == SEE_SEL) && !sel_match)
        begin
            next_state = SEE_IDLE;
        end
        else if (ack_done)
        begin
            unique case (state)
                SEE_SEL: next_state = rx_sel_read ? SEE_RDATA : SEE_ADDR_HI;
                SEE_ADDR_HI: next_state = SEE_ADDR_LO;
                SEE_ADDR_LO: next_state = SEE_WDATA;
                SEE_RDATA: next_state = sda_s ? SEE_IDLE : SEE_RDATA;
                default: next_state = state;
            endcase
        end
    end
    always_ff @(posedge mclk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            state <= SEE_IDLE;
            program_busy <= 1'b0;
        end
        else
        begin
            state <= next_state;
            program_busy <= (next_state == SEE_PROG);
        end
    end

    always_ff @(posedge mclk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            bit_cnt <= SEE_BIT_FIRST;
            sh <= 8'h00;
        end
        else if (start_ev || !active)
        begin
            bit_cnt <= SEE_BIT_FIRST;
        end
        else if (scl_rise)
        begin
            bit_cnt <= (bit_cnt == SEE_ACK_SLOT) ? SEE_BIT_FIRST : bit_cnt + 4'h1;
            if (bit_cnt != SEE_ACK_SLOT)
            begin
                sh <= rx_byte;
            end
        end
    end

    // protect level latched from start through the address bytes
    always_ff @(posedge mclk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            wp_seen <= 1'b0;
            ack_pend <= 1'b0;
        end
        else
        begin
            if (start_ev && !busy)
            begin
                wp_seen <= wp_s;
            end
            else if (wp_s && ((state == SEE_SEL) || (state == SEE_ADDR_HI)
                || (state == SEE_ADDR_LO)))
            begin
                wp_seen <= 1'b1;
            end
            if (byte_done)
            begin
                unique case (state)
                    SEE_SEL: ack_pend <= sel_match;
                    SEE_WDATA: ack_pend <= !wp_seen;
                    SEE_RDATA: ack_pend <= 1'b0;
                    default: ack_pend <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data line drive, set on falling clock, released at once on start, stop or when not active
    always_ff @(posedge mclk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            tx <= 8'h00;
        end
        else if (!active || start_ev || stop_ev)
        begin
            sda_oe <= 1'b0;
        end
        else if (scl_fall)
        begin
            if (bit_cnt == SEE_ACK_SLOT)
            begin
                sda_oe <= ack_pend;
            end
            else if (state == SEE_RDATA && bit_cnt == SEE_BIT_FIRST)
            begin
                sda_oe <= ~rd_byte[7];
                tx <= {rd_byte[6:0], 1'b0};
            end
            else if (state == SEE_RDATA)
            begin
                sda_oe <= ~tx[7];
                tx <= {tx[6:0], 1'b0};
            end
            else
            begin
                sda_oe <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address counter
    always_ff @(posedge mclk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            addr <= '0;
        end
        else if (ack_done)
        begin
            unique case (state)
                SEE_SEL:
                begin
                    if (!rx_sel_read)
                    begin
                        addr[SEE_ADDR_W-1] <= sh[SEE_SEL_TOP];
                    end
                end
                SEE_ADDR_HI: addr[15:8] <= sh;
                SEE_ADDR_LO: addr[7:0] <= sh;
                SEE_WDATA:
                begin
                    if (!wp_seen)
                    begin
                        addr[7:0] <= addr[7:0] + 8'h01;
                    end
                end
                SEE_RDATA: addr <= addr + SEE_ADDR_W'(1);
                default: addr <= addr;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // page buffer, committed only after a valid stop
    always_ff @(posedge mclk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            valid <= '0;
        end
        else if (start_ev && !busy)
        begin
            valid <= '0;
        end
        else if (wr_ok)
        begin
            valid[addr[7:0]] <= 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (wr_ok)
        begin
            page_buf[addr[7:0]] <= sh;
        end
    end

    always_ff @(posedge mclk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            timer <= '0;
            prog_idx <= '0;
            commit_on <= 1'b0;
        end
        else if (prog_trig && !busy)
        begin
            timer <= '0;
            prog_idx <= '0;
            commit_on <= 1'b1;
        end
        else if (busy)
        begin
            timer <= timer + TW'(1);
            prog_idx <= prog_idx + 8'h01;
            if (prog_idx == 8'hff)
            begin
                commit_on <= 1'b0;
            end
        end
    end

    // array starts erased with matching check bits
    always_ff @(posedge mclk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            for (int w = 0; w < WORDS; w++)
            begin
                mem[w] <= {see_check(SEE_ERASED), SEE_ERASED};
            end
        end
        else if (commit)
        begin
            mem[pg_index] <= {see_check(merged), merged};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence sel_byte_s;
        byte_done && (state == SEE_SEL) && sel_match;
    endsequence
    sequence busy_entry_s;
        $rose(busy);
    endsequence

    busy_quiet_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        busy |=> !sda_oe)
        else $error("line driven while programming");
    sel_ack_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        sel_byte_s ##1 (!start_ev && !stop_ev && !scl_rise) [*2] |-> ack_pend)
        else $error("matching select not acknowledged");
    sel_miss_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        (byte_done && state == SEE_SEL && !sel_match && !start_ev && !stop_ev)
        |=> state == SEE_IDLE ##1 !sda_oe)
        else $error("mismatched select kept active");
    wp_nack_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        (byte_done && state == SEE_WDATA && wp_seen) |=> !ack_pend)
        else $error("protected data acknowledged");
    no_prog_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        (stop_ev && !busy && bit_cnt != SEE_BIT_FIRST + 4'h1) |=> !busy)
        else $error("stop out of slot started programming");
    prog_go_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        (prog_trig && !busy) |=> busy ##1 program_busy)
        else $error("valid stop did not program");
    page_wrap_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        wr_ok |=> (addr[SEE_ADDR_W-1:8] == $past(addr[SEE_ADDR_W-1:8]))
        && (addr[7:0] == 8'($past(addr[7:0]) + 8'h01)))
        else $error("page address left its row");
    read_inc_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        (ack_done && state == SEE_RDATA && !start_ev && !stop_ev)
        |=> addr == SEE_ADDR_W'($past(addr) + SEE_ADDR_W'(1)))
        else $error("read counter not incremented");
    read_nack_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        (ack_done && state == SEE_RDATA && sda_s && !start_ev && !stop_ev)
        |=> state == SEE_IDLE)
        else $error("read continued after nack");
    restart_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        (start_ev && !busy) |=> (state == SEE_SEL) && (bit_cnt == SEE_BIT_FIRST))
        else $error("start did not restart decoding");
    prog_len_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        busy_entry_s |-> busy [*8])
        else $error("programming ended early");
endmodule // see_slave

// File: testbench/see_bus_master.sv
module see_bus_master
(
    input wire logic mclk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_m
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // data moves mid low phase, sampled mid high phase
    task automatic bit_x(input logic b, output logic seen);
        tick(2);
        sda_m <= b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        seen = sda_wire;
        tick(2);
        scl <= 1'b0;
    endtask

    // waits for the device to let go of an ack first
    task automatic start_cond();
        tick(4);
        sda_m <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_m <= 1'b0;
        tick(4);
        scl <= 1'b0;
    endtask

    task automatic stop_cond();
        tick(4);
        sda_m <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_m <= 1'b1;
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // msb first, ninth slot released for the answer
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(d[i], s);
        end
        bit_x(1'b1, s);
        ack = ~s;
    endtask

    task automatic rd_byte(input logic ack_m, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'b1, s);
            d[i] = s;
        end
        bit_x(~ack_m, s);
    endtask
endmodule // see_bus_master

// File: testbench/test_serial_eeprom_bus_slave.sv
module test_serial_eeprom_bus_slave;
    timeunit 1ns;
    timeprecision 1ps;
    import see_pkg::*;

    logic mclk;
    logic rst_n;
    logic scl;
    logic sda_m;
    wire logic sda_wire;
    logic sda_out;
    logic sda_oe;
    logic st_lo;
    logic st_hi;
    logic wp;
    logic program_busy;
    logic [15:0] seed;
    logic [7:0] mem [int];
    int n_fail;
    int check_count;

    // open drain with pull-up
    assign sda_wire = sda_m & ~sda_oe;

    see_slave #(.PROG_CYCLES(300)) u_dut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .chip_strap_low(st_lo),
        .chip_strap_high(st_hi), .write_protect_input(wp), .program_busy(program_busy));

    see_bus_master u_master (.mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_m(sda_m));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction

    function automatic logic [7:0] exp_byte(input logic [16:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
    endfunction

    function automatic logic [7:0] sel_byte(input logic rd, input logic top);
        return {SEE_TYPE_ID, st_hi, st_lo, top, rd};
    endfunction

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, n_fail);
    endtask

    task automatic settle_busy(input logic exp);
        repeat (6) @(posedge mclk);
        check(8'(program_busy), 8'(exp));
    endtask

    task automatic set_addr(input logic [16:0] a);
        logic ack;
        u_master.start_cond();
        u_master.wr_byte(sel_byte(1'b0, a[16]), ack);
        check(8'(ack), 8'h01);
        u_master.wr_byte(a[15:8], ack);
        check(8'(ack), 8'h01);
        u_master.wr_byte(a[7:0], ack);
        check(8'(ack), 8'h01);
    endtask

    task automatic read_from(input logic [16:0] a, input int n);
        logic ack;
        logic [7:0] d;
        set_addr(a);
        u_master.start_cond();
        u_master.wr_byte(sel_byte(1'b1, a[16]), ack);
        check(8'(ack), 8'h01);
        for (int i = 0; i < n; i++)
        begin
            u_master.rd_byte(i < n - 1, d);
            check(d, exp_byte(a));
            a = a + 17'h1;
        end
        u_master.bit_x(1'b1, ack);
        check(8'(ack), 8'h01);
        u_master.stop_cond();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic ack;
        logic [7:0] d;
        logic [16:0] a;
        int polls;
        seed = 16'h0010;
        n_fail = 0;
        check_count = 0;
        rst_n = 1'b0;
        wp = 1'b0;
        {st_hi, st_lo} = 2'(rnd() % 4);
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (10) @(posedge mclk);
        check(8'(sda_oe), 8'h00);
        check(8'(sda_out), 8'h00);
        check(8'(program_busy), 8'h00);
        // wrong identifier, then each strap wrong
        for (int k = 0; k < 3; k++)
        begin
            u_master.start_cond();
            d = sel_byte(1'b0, 1'b0) ^ (k == 0 ? 8'h40 : (k == 1 ? 8'h08 : 8'h04));
            u_master.wr_byte(d, ack);
            check(8'(ack), 8'h00);
            u_master.stop_cond();
        end
        done("select");
        // page write crossing the row end wraps inside the row
        a = {1'b1, rnd()};
        a[7:0] = 8'hfe;
        set_addr(a);
        for (int i = 0; i < 4; i++)
        begin
            d = 8'(rnd());
            mem[int'({a[16:8], 8'(a[7:0] + i)})] = d;
            u_master.wr_byte(d, ack);
            check(8'(ack), 8'h01);
        end
        u_master.stop_cond();
        settle_busy(1'b1);
        polls = 0;
        ack = 1'b0;
        while (!ack)
        begin
            u_master.start_cond();
            u_master.wr_byte(sel_byte(1'b1, 1'b0), ack);
            if (!ack)
                polls++;
            if (polls > 20)
            begin
                n_fail++;
                give_verdict();
            end
        end
        check(8'(polls > 0), 8'h01);
        u_master.rd_byte(1'b0, d);
        check(d, exp_byte({a[16:8], 8'h02}));
        u_master.stop_cond();
        done("page");
        read_from(a, 4);
        read_from({a[16:8], 8'h00}, 4);
        done("random");
        // protected write: memory kept, reads unaffected
        wp <= 1'b1;
        a = {rnd(), 1'b0};
        set_addr(a);
        u_master.wr_byte(8'(rnd()), ack);
        check(8'(ack), 8'h00);
        u_master.stop_cond();
        settle_busy(1'b0);
        read_from(a, 2);
        wp <= 1'b0;
        done("protect");
        // stop inside a data byte programs nothing
        set_addr(a);
        u_master.wr_byte(8'(rnd()), ack);
        check(8'(ack), 8'h01);
        u_master.bit_x(1'b0, ack);
        u_master.stop_cond();
        settle_busy(1'b0);
        read_from(a, 1);
        done("late_stop");
        // restart mid byte goes back to select decoding
        set_addr(a);
        for (int i = 0; i < 4; i++)
        begin
            u_master.bit_x(1'(rnd()), ack);
        end
        u_master.start_cond();
        u_master.wr_byte(sel_byte(1'b1, 1'b0), ack);
        check(8'(ack), 8'h01);
        u_master.rd_byte(1'b0, d);
        check(d, exp_byte(a));
        u_master.stop_cond();
        settle_busy(1'b0);
        done("abort");
        read_from(17'h1ffff, 2);
        done("wrap");
        give_verdict();
    end
endmodule // test_serial_eeprom_bus_slave
